/* inc/vid_decode_consts.svh */
// Offsets, field positions, reset values and address map of the instance decoder.
`ifndef VID_DECODE_CONSTS_SVH
`define VID_DECODE_CONSTS_SVH
// Register indices; the bus byte address is four times the index.
`define IDX_ADAPTER_ID_LOW      3'h0
`define IDX_ADAPTER_ID_HIGH     3'h1
`define IDX_ROM_AND_INST_SEL    3'h2
`define IDX_MODE_CTRL           3'h3
`define IDX_STATUS              3'h4
// Slot configuration register fields.
`define SLOT_ROM_MSB            7
`define SLOT_ROM_LSB            4
`define SLOT_INST_MSB           3
`define SLOT_INST_LSB           1
`define SLOT_ENA_BIT            0
`define SLOT_CFG_RESET          8'h00
// Mode control register fields.
`define MODE_SEL_MSB            1
`define MODE_SEL_LSB            0
`define MODE_LEGACY_EN_BIT      2
`define MODE_CTRL_RESET         8'h00
// Memory and I/O placement.
`define ROM_REGION_TOP3         3'h6
`define ROM_AREA_LIMIT          13'h1C00
`define COP_AREA_TOP3           3'h7
`define IO_BANK_BASE            16'h2100
`define LEGACY_MEM_TOP3         3'h5
`define LEGACY_IO_LOW           16'h03B0
`define LEGACY_IO_HIGH          16'h03DF
// Bus responses.
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`define RESP_DECERR             2'h3
`endif

/* inc/vid_decode_pkg.sv */
// Types shared by the instance decoder and its environment.
package vid_decode_pkg;
	typedef enum logic [1:0] {
		MODE_LEGACY   = 2'h0,
		MODE_TEXT132  = 2'h1,
		MODE_EXTENDED = 2'h2,
		MODE_SPARE    = 2'h3
	} mode_e;
	typedef struct packed {
		logic [3:0] rom_block;
		logic [2:0] instance_no;
		logic       enable;
	} slot_cfg_s;
	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic [19:0] addr;
	} dec_req_s;
	typedef struct packed {
		logic rom;
		logic cop;
		logic ioreg;
		logic legacy;
	} dec_hit_s;
endpackage : vid_decode_pkg

/* src/video_instance_address_decode.sv */
// Slot configuration registers and address decode for one graphics instance.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "vid_decode_consts.svh"
module video_instance_address_decode #(
	parameter logic [15:0] ADAPTER_ID = 16'h5A3C // Arbitrary identifier value.
) (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// Slot configuration load from the system configuration logic.
	input  wire logic                        cfg_load,
	input  wire vid_decode_pkg::slot_cfg_s   cfg_data,
	// Address decode request and result.
	input  wire vid_decode_pkg::dec_req_s    dec_req,
	output logic                             dec_valid_r,
	output vid_decode_pkg::dec_hit_s         dec_hit_r,
	output logic                             display_active_r,
	// AXI4-Lite write channels.
	input  wire logic [7:0]                  awaddr,
	input  wire logic                        awvalid,
	output logic                             awready_r,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready_r,
	output logic [1:0]                       bresp_r,
	output logic                             bvalid_r,
	input  wire logic                        bready,
	// AXI4-Lite read channels.
	input  wire logic [7:0]                  araddr,
	input  wire logic                        arvalid,
	output logic                             arready_r,
	output logic [31:0]                      rdata_r,
	output logic [1:0]                       rresp_r,
	output logic                             rvalid_r,
	input  wire logic                        rready
);
	import vid_decode_pkg::*;

	slot_cfg_s   slot_r;
	logic [7:0]  mode_ctrl_r;
	logic [7:0]  wr_addr_r;
	logic [7:0]  wr_data_r;
	logic        wr_strb0_r;
	logic        aw_held_r;
	logic        w_held_r;
	mode_e       mode;
	logic        legacy_en;
	logic        legacy_mode;
	logic [15:0] io_bank;
	logic [2:0]  wr_idx;
	logic [2:0]  rd_idx;
	logic        do_write;
	logic [7:0]  rd_byte;
	logic [1:0]  rd_resp;
	dec_hit_s    hit_nxt;

	// ------------------------------------------------------------------
	// Slot configuration
	// ------------------------------------------------------------------

	// Only the configuration port loads the slot register; the bus never can.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_r <= slot_cfg_s'(`SLOT_CFG_RESET);
		end else if (cfg_load) begin
			slot_r <= cfg_data;
		end
	end

	assign mode        = mode_e'(mode_ctrl_r[`MODE_SEL_MSB:`MODE_SEL_LSB]);
	assign legacy_en   = mode_ctrl_r[`MODE_LEGACY_EN_BIT];
	assign legacy_mode = (mode == MODE_LEGACY) || (mode == MODE_TEXT132);
	// Each instance gets its own 16-byte I/O bank, so eight never overlap.
	assign io_bank     = `IO_BANK_BASE | {9'h000, slot_r.instance_no, 4'h0};

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------

	// Decode is purely from configuration and mode; a disabled slot claims nothing.
	always_comb begin
		hit_nxt = '0;
		if (slot_r.enable) begin
			if (dec_req.is_io) begin
				// Sixteen registers per bank, bank chosen by instance number.
				hit_nxt.ioreg  = (dec_req.addr[15:4] == io_bank[15:4]);
				hit_nxt.legacy = legacy_mode && legacy_en
					&& (dec_req.addr[15:0] >= `LEGACY_IO_LOW)
					&& (dec_req.addr[15:0] <= `LEGACY_IO_HIGH);
			end else begin
				if (dec_req.addr[19:13] == {`ROM_REGION_TOP3, slot_r.rom_block}) begin
					hit_nxt.rom = (dec_req.addr[12:0] < `ROM_AREA_LIMIT);
					hit_nxt.cop = (dec_req.addr[12:10] == `COP_AREA_TOP3)
						&& (dec_req.addr[9:7] == slot_r.instance_no);
				end
				// Update accesses are ignored without the legacy enable.
				hit_nxt.legacy = legacy_mode && legacy_en
					&& (dec_req.addr[19:17] == `LEGACY_MEM_TOP3);
			end
		end
	end

	// Results are registered so every decode output comes from a flip-flop.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_valid_r <= 1'b0;
			dec_hit_r   <= '0;
		end else begin
			dec_valid_r <= dec_req.valid;
			dec_hit_r   <= dec_req.valid ? hit_nxt : '0;
		end
	end

	// The picture keeps running whatever the legacy enable says.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			display_active_r <= 1'b0;
		end else begin
			display_active_r <= slot_r.enable;
		end
	end

	// ------------------------------------------------------------------
	// Bus write path
	// ------------------------------------------------------------------

	assign wr_idx   = wr_addr_r[4:2];
	assign do_write = aw_held_r && w_held_r && !bvalid_r;

	// Address and data are taken independently and in either order.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else if (awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_held_r <= 1'b1;
			wr_addr_r <= awaddr;
		end else if (bvalid_r && bready) begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wready_r   <= 1'b1;
			w_held_r   <= 1'b0;
			wr_data_r  <= 8'h00;
			wr_strb0_r <= 1'b0;
		end else if (wvalid && wready_r) begin
			wready_r   <= 1'b0;
			w_held_r   <= 1'b1;
			wr_data_r  <= wdata[7:0];
			wr_strb0_r <= wstrb[0];
		end else if (bvalid_r && bready) begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
		end
	end

	// Only the mode control register is writable; identifier and slot bytes refuse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ctrl_r <= `MODE_CTRL_RESET;
		end else if (do_write && (wr_addr_r[1:0] == 2'h0) && (wr_addr_r[7:5] == 3'h0)
				&& (wr_idx == `IDX_MODE_CTRL) && wr_strb0_r) begin
			mode_ctrl_r <= {5'h00, wr_data_r[2:0]};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			// Upper address bits are decoded too, so no alias can reach the mode register.
			if (wr_addr_r[1:0] != 2'h0 || wr_addr_r[7:5] != 3'h0 || wr_idx > `IDX_STATUS) begin
				bresp_r <= `RESP_DECERR;
			end else if (wr_idx == `IDX_MODE_CTRL) begin
				bresp_r <= `RESP_OKAY;
			end else begin
				bresp_r <= `RESP_SLVERR;
			end
		end else if (bvalid_r && bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Bus read path
	// ------------------------------------------------------------------

	assign rd_idx = araddr[4:2];

	// Each register is one byte in the low lane; upper bits read as zero.
	always_comb begin
		rd_byte = 8'h00;
		rd_resp = `RESP_OKAY;
		if (araddr[1:0] != 2'h0 || araddr[7:5] != 3'h0) begin
			rd_resp = `RESP_DECERR;
		end else begin
			case (rd_idx)
				`IDX_ADAPTER_ID_LOW:   rd_byte = ADAPTER_ID[7:0];
				`IDX_ADAPTER_ID_HIGH:  rd_byte = ADAPTER_ID[15:8];
				`IDX_ROM_AND_INST_SEL: rd_byte = slot_r;
				`IDX_MODE_CTRL:        rd_byte = mode_ctrl_r;
				`IDX_STATUS:           rd_byte = {4'h0, dec_hit_r};
				default:               rd_resp = `RESP_DECERR;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= `RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= {24'h00_0000, rd_byte};
			rresp_r   <= rd_resp;
		end else if (rvalid_r && rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_ar_taken;
		arvalid && arready_r;
	endsequence
	sequence s_write_done;
		do_write;
	endsequence

	AST_ID_LOW: assert property (s_ar_taken ##0 (araddr == 8'h00) |=>
		rvalid_r && rdata_r == {24'h00_0000, ADAPTER_ID[7:0]})
		else $error("Identifier low byte read wrong.");
	AST_ID_HIGH: assert property (s_ar_taken ##0 (araddr == 8'h04) |=>
		rvalid_r && rdata_r == {24'h00_0000, ADAPTER_ID[15:8]})
		else $error("Identifier high byte read wrong.");
	AST_SLOT_RO: assert property (!cfg_load |=> $stable(slot_r))
		else $error("Slot register changed without a configuration load.");
	AST_RO_WRITE_ERR: assert property (s_write_done ##0 (wr_addr_r == 8'h08) |=>
		bvalid_r && bresp_r == `RESP_SLVERR)
		else $error("Write to slot register not refused.");
	AST_COP_SECTION: assert property (dec_valid_r && dec_hit_r.cop |->
		$past(dec_req.addr[9:7]) == $past(slot_r.instance_no))
		else $error("Coprocessor hit outside own section.");
	AST_ROM_LIMIT: assert property (dec_req.valid && !dec_req.is_io && slot_r.enable
		&& dec_req.addr[19:13] == {`ROM_REGION_TOP3, slot_r.rom_block}
		&& dec_req.addr[12:10] == 3'h7 |=> !dec_hit_r.rom)
		else $error("ROM decoded in the register kilobyte.");
	AST_LEGACY_GATED: assert property (dec_req.valid && !legacy_en |=> !dec_hit_r.legacy)
		else $error("Legacy decode while disabled.");
	AST_EXT_NO_LEGACY: assert property (dec_req.valid && mode == MODE_EXTENDED |=>
		!dec_hit_r.legacy)
		else $error("Legacy decode in extended mode.");
	AST_IO_BANK: assert property (dec_valid_r && dec_hit_r.ioreg |->
		$past(dec_req.addr[6:4]) == $past(slot_r.instance_no))
		else $error("I/O bank hit outside own location.");
	AST_DISPLAY: assert property (cfg_load && cfg_data.enable ##1 !cfg_load |=>
		display_active_r)
		else $error("Display not active after enable.");
	AST_BRESP_HOLD: assert property (bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
		else $error("Write response dropped before taken.");

endmodule : video_instance_address_decode

/* verification/slot_config_source.sv */
// Model of the configuration logic that loads the slot register at start-up.
`timescale 1ns/1ps
module slot_config_source (
	// Clock.
	input  wire logic                  clk,
	// Load toward the decoder.
	output logic                       cfg_load,
	output vid_decode_pkg::slot_cfg_s  cfg_data
);
	import vid_decode_pkg::*;
	// ------------------------------------------------------------------
	// Configuration pass
	// ------------------------------------------------------------------
	// Idle until the first configuration pass.
	initial begin
		cfg_load = 1'b0;
		cfg_data = '0;
	end
	// One pulse per pass; afterwards the data is inverted, so a decoder that keeps
	// looking at the port instead of its own register is caught.
	task automatic load(input slot_cfg_s v);
		@(posedge clk);
		cfg_load <= 1'b1;
		cfg_data <= v;
		@(posedge clk);
		cfg_load <= 1'b0;
		cfg_data <= ~v;
	endtask : load
endmodule : slot_config_source

/* verification/video_instance_address_decode_tb_top.sv */
// Self-checking bench for the instance address decoder.
`timescale 1ns/1ps
`include "vid_decode_consts.svh"
module video_instance_address_decode_tb_top;
	import vid_decode_pkg::*;
	localparam logic [15:0] ID = 16'hA5C3; // Arbitrary identifier value.
	logic clk = 1'b0, rst_n = 1'b0;
	logic cfg_load, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	slot_cfg_s cfg_data;
	dec_req_s dec_req = '0;
	dec_hit_s dec_hit_r;
	logic dec_valid_r, display_active_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata_r;
	logic [3:0] wstrb = '0;
	logic [1:0] bresp_r, rresp_r, rsp;
	logic [31:0] rd;
	int failures = 0, n_compared = 0, cycles = 0;
	// The clock runs at 40 MHz.
	always #12.5 clk = ~clk;
	// A hang is cut short well past the expected run length.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			close_out();
		end
	end
	slot_config_source i_slot_config_source (.clk(clk), .cfg_load(cfg_load), .cfg_data(cfg_data));
	video_instance_address_decode #(.ADAPTER_ID(ID)) i_video_instance_address_decode (
		.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load), .cfg_data(cfg_data),
		.dec_req(dec_req), .dec_valid_r(dec_valid_r), .dec_hit_r(dec_hit_r),
		.display_active_r(display_active_r), .awaddr(awaddr), .awvalid(awvalid),
		.awready_r(awready_r), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready_r(wready_r), .bresp_r(bresp_r), .bvalid_r(bvalid_r), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready_r(arready_r), .rdata_r(rdata_r),
		.rresp_r(rresp_r), .rvalid_r(rvalid_r), .rready(rready));
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	// Count a comparison and report it at once when it differs.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Both write channels are offered together and each is released once taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done, w_done;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_done = 0;
		w_done = 0;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awready_r && !aw_done) begin
				awvalid <= 1'b0;
				aw_done = 1;
			end
			if (wready_r && !w_done) begin
				wvalid <= 1'b0;
				w_done = 1;
			end
		end
		while (bvalid_r !== 1'b1) @(posedge clk);
		r = bresp_r;
		bready <= 1'b0;
	endtask : axw
	// Read one register; data and response are taken at the answering edge.
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready_r !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid_r !== 1'b1);
		d = rdata_r;
		r = rresp_r;
		rready <= 1'b0;
	endtask : axr
	// One decode request; the result stands in the cycle after it is sampled.
	task automatic dck(input logic io, input logic [19:0] a, input logic [3:0] exp);
		@(posedge clk);
		dec_req <= '{valid: 1'b1, is_io: io, addr: a};
		@(posedge clk);
		dec_req <= '0;
		#1;
		chk({dec_valid_r, dec_hit_r}, {1'b1, exp});
	endtask : dck
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Identifier bytes and slot reset value, before any configuration pass.
	task automatic t_ident();
		axr(8'h00, rd, rsp);
		chk(rd, {24'h0, ID[7:0]});
		chk(rsp, `RESP_OKAY);
		axr(8'h04, rd, rsp);
		chk(rd, {24'h0, ID[15:8]});
		axr(8'h08, rd, rsp);
		chk(rd, 32'h0);
		chk(rsp, `RESP_OKAY);
	endtask : t_ident
	// Every instance number in turn, with a different ROM block each time.
	task automatic t_place();
		logic [19:0] blk, cop;
		for (int i = 0; i < 8; i++) begin
			i_slot_config_source.load({4'(2 * i + 1), 3'(i), 1'b1});
			axr(8'h08, rd, rsp);
			chk(rd, {24'h0, 4'(2 * i + 1), 3'(i), 1'b1});
			blk = 20'hC0000 + 20'(2 * i + 1) * 20'h2000;
			cop = blk + 20'h1C00 + 20'(i) * 20'h80;
			dck(1'b0, blk, 4'h8);
			dck(1'b0, blk + 20'h1BFF, 4'h8);
			dck(1'b0, cop, 4'h4);
			dck(1'b0, cop + 20'h7F, 4'h4);
			dck(1'b0, blk + 20'h1C00 + 20'((i + 1) % 8) * 20'h80, 4'h0);
			dck(1'b1, 20'h2100 + 20'(i) * 20'h10, 4'h2);
			dck(1'b1, 20'h210F + 20'(i) * 20'h10, 4'h2);
			dck(1'b1, 20'h2100 + 20'((i + 1) % 8) * 20'h10, 4'h0);
		end
	endtask : t_place
	// Bus writes to the slot and identifier low registers and to an unmapped place.
	// The slot holds 0xFF here, so a write of zero that landed would show.
	task automatic t_ro();
		axw(8'h08, 32'h00, rsp);
		chk(rsp, `RESP_SLVERR);
		axw(8'h00, 32'h00, rsp);
		chk(rsp, `RESP_SLVERR);
		axw(8'h2C, 32'h07, rsp);
		chk(rsp, `RESP_DECERR);
		axr(8'h0C, rd, rsp);
		chk(rd, 32'h0);
		axr(8'h08, rd, rsp);
		chk(rd, 32'hFF);
		axr(8'h00, rd, rsp);
		chk(rd, {24'h0, ID[7:0]});
		dck(1'b0, 20'hDFC00 + 20'h380, 4'h4);
		axr(8'h14, rd, rsp);
		chk(rsp, `RESP_DECERR);
	endtask : t_ro
	// Legacy decode in every mode, then decode off with the picture still on.
	task automatic t_legacy();
		i_slot_config_source.load({4'h0, 3'h0, 1'b1});
		for (int m = 0; m < 4; m++) begin
			axw(8'h0C, 32'h4 | m, rsp);
			chk(rsp, `RESP_OKAY);
			axr(8'h0C, rd, rsp);
			chk(rd, 32'h4 | m);
			chk(rd & 32'h3, 32'(m));
			dck(1'b0, 20'hBFFFF, {3'h0, m < 2});
			dck(1'b1, 20'h003C0, {3'h0, m < 2});
		end
		// Legacy decode goes off in the mode register; the slot enable stays set.
		axw(8'h0C, 32'h0, rsp);
		dck(1'b0, 20'hA0000, 4'h0);
		chk(display_active_r, 1'b1);
	endtask : t_legacy
	// A disabled slot decodes nothing and shows no picture.
	task automatic t_off();
		i_slot_config_source.load({4'h0, 3'h0, 1'b0});
		dck(1'b0, 20'hC0000, 4'h0);
		chk(display_active_r, 1'b0);
	endtask : t_off
	// Print the verdict and end the run.
	task automatic close_out();
		if (failures == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_ident();
		t_place();
		t_ro();
		t_legacy();
		t_off();
		close_out();
	end
endmodule : video_instance_address_decode_tb_top
